/* File: asc_codec_model.sv */
// Behavioural codec on the far side of the serial link
`timescale 1ns/1ps
module asc_codec_model (
    input wire logic run_i,
    input wire logic reset_n_i,
    input wire logic sync_i,
    input wire logic sdo_i,
    input wire logic ret_en_i,
    input wire logic [6:0] ret_idx_i,
    input wire logic [15:0] ret_dat_i,
    output logic bclk_o,
    output logic sdi_o,
    output logic [19:0] slot3_o,
    output int frames_o
);
    int cnt = 0;
    int ix;
    logic sq = 1'b0;
    logic al = 1'b0;
    logic [19:0] sh = '0;

    function automatic logic fbit(input int i);
        if (i == 0) begin
            return 1'b1;
        end
        if (i == 1) begin
            return ret_en_i;
        end
        if (i >= 17 && i <= 23) begin
            return ret_en_i & ret_idx_i[23-i];
        end
        if (i >= 36 && i <= 51) begin
            return ret_en_i & ret_dat_i[51-i];
        end
        return 1'b0;
    endfunction

    // Offset keeps bit clock edges off the system clock edges
    initial begin
        bclk_o = 1'b0;
        sdi_o = 1'b0;
        slot3_o = '0;
        frames_o = 0;
        #1.25;
        forever begin
            #40;
            // Clock and data held low while stopped or in cold reset
            if (run_i && reset_n_i) begin
                bclk_o = ~bclk_o;
            end else begin
                bclk_o = 1'b0;
                sdi_o = 1'b0;
            end
        end
    end

    // Data launched on rising bit clock, bit 0 predicted from cadence
    always @(posedge bclk_o) begin
        sdi_o <= fbit(cnt % 256);
        cnt = cnt + 1;
    end

    always @(negedge bclk_o) begin
        ix = (cnt + 255) % 256;
        if (sync_i && !sq) begin
            cnt = 1;
            al = 1'b1;
            ix = 0;
        end
        sq = sync_i;
        if (al && ix >= 56 && ix <= 75) begin
            sh = {sh[18:0], sdo_i};
        end
        if (al && ix == 75) begin
            slot3_o = sh;
            frames_o = frames_o + 1;
        end
    end
endmodule

/* File: asc_ctrl.sv */
// Audio serial controller: setup, link resets, codec register access
// Behaviour
// - Controller starts disabled after any reset
// - Config bit selects internal or external codec
// - Serial framing sets justification, clock directions, divider
// - Enable bit write turns controller on
// - Soft reset restores registers, flushes both FIFOs
// - Flush empties FIFOs, keeps other registers
// - No sync for four frames after power-down
// - Cold reset holds reset low at least 1us
// - Warm reset holds sync high at least 1us while the AC-link is not running
// - Address and data writes in either order
// - Done flag set once request is sent
// - Returned index and data captured, flag set
// - Interrupt raised when status flag set, enabled
// - AC-link transmission runs when enabled, samples gated
// - Replay off sends zero samples
// - Empty FIFO sends zero or last sample
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_ctrl import asc_pkg::*; #(
    parameter int PD_HOLD_CYC = `ASC_PD_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic bit_clk_i,
    output logic bit_clk_o,
    output logic bit_clk_oe_o,
    output logic frame_sync_o,
    output logic frame_sync_oe_o,
    input wire logic sdata_in_i,
    output logic sdata_out_o,
    output logic codec_reset_n_o,
    input wire logic [19:0] tx_data_i,
    input wire logic tx_empty_i,
    output logic tx_pop_o,
    output logic fifo_flush_o,
    output logic internal_codec_select_o,
    output logic justification_select_o
);
    localparam int COLD_CYC = `ASC_COLD_CYC;
    localparam int WARM_CYC = `ASC_WARM_CYC;

    asc_state_t s;
    asc_state_t n;
    logic [1:0] pins_q;
    logic bc_s;
    logic sdi_s;
    logic cold_busy;
    logic warm_busy;
    logic pd_busy;
    logic req;
    logic wr;
    logic rise;
    logic fall;
    logic link;
    logic play;
    logic req_ok;
    logic [19:0] smp;
    logic [19:0] word;
    logic [19:0] ish_n;
    logic [31:0] cfg_rd;
    logic [31:0] wv;
    logic [7:0] bi;

    asc_sync3 u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({sdata_in_i, bit_clk_i}),
        .q_o(pins_q)
    );
    assign bc_s = pins_q[0];
    assign sdi_s = pins_q[1];

    asc_pulse #(.LEN(COLD_CYC)) u_cold (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(s.cold),
        .busy_o(cold_busy)
    );

    asc_pulse #(.LEN(WARM_CYC)) u_warm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(s.warm),
        .busy_o(warm_busy)
    );

    // Holdoff counted on the system clock: the bit clock is dead by then
    asc_pulse #(.LEN(PD_HOLD_CYC)) u_pdhold (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(s.pd_go),
        .busy_o(pd_busy)
    );

    function automatic logic [31:0] wmask(input logic [31:0] o,
            input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (o & ~m) | (d & m);
    endfunction

    always_comb begin
        cfg_rd = '0;
        cfg_rd[`ASC_CFG_EN] = s.en;
        cfg_rd[`ASC_CFG_ICDC] = s.icdc;
        cfg_rd[`ASC_CFG_FMT] = s.fmt;
        cfg_rd[`ASC_CFG_BCKD] = s.bckd;
        cfg_rd[`ASC_CFG_SYNCD] = s.syncd;
        cfg_rd[`ASC_CFG_LSMP] = s.lsmp;
        cfg_rd[`ASC_CFG_AMSL] = s.amsl;
    end

    always_comb begin
        n = s;
        n.pop = 1'b0;
        n.flush = 1'b0;
        n.cold = 1'b0;
        n.warm = 1'b0;
        n.pd_go = 1'b0;
        req = wb_cyc_i & wb_stb_i;
        wr = req & wb_we_i & s.ack;
        n.ack = req & ~s.ack;
        wv = '0;
        word = s.osh;
        smp = '0;
        ish_n = {s.ish[18:0], sdi_s};
        bi = s.pos - 8'h01;
        // Read data captured in the request cycle, valid with ack
        if (req && !s.ack) begin
            case (wb_adr_i)
                `ASC_CFG_OFS: n.rdat = cfg_rd;
                `ASC_CTL_OFS: n.rdat = {30'h0, s.replay, 1'b0};
                `ASC_CAD_OFS: n.rdat = {24'h0, s.cmd_rd, s.cmd_idx};
                `ASC_CDA_OFS: n.rdat = {16'h0, s.cmd_dat};
                `ASC_STA_OFS: n.rdat = {28'h0, pd_busy, s.ready,
                                        s.rcvd, s.done};
                `ASC_SAD_OFS: n.rdat = {25'h0, s.st_idx};
                `ASC_SDA_OFS: n.rdat = {16'h0, s.st_dat};
                `ASC_IEN_OFS: n.rdat = {31'h0, s.irq_en};
                `ASC_DIV_OFS: n.rdat = {24'h0, s.div};
                default: n.rdat = '0;
            endcase
        end
        // Writes take effect on the edge that the master sees ack
        if (wr) begin
            case (wb_adr_i)
                `ASC_CFG_OFS: begin
                    wv = wmask(cfg_rd, wb_dat_i, wb_sel_i);
                    n.en = wv[`ASC_CFG_EN];
                    n.icdc = wv[`ASC_CFG_ICDC];
                    n.fmt = asc_fmt_t'(wv[`ASC_CFG_FMT]);
                    n.bckd = wv[`ASC_CFG_BCKD];
                    n.syncd = wv[`ASC_CFG_SYNCD];
                    n.lsmp = wv[`ASC_CFG_LSMP];
                    n.amsl = wv[`ASC_CFG_AMSL];
                end
                `ASC_CTL_OFS: begin
                    wv = wmask({30'h0, s.replay, 1'b0}, wb_dat_i, wb_sel_i);
                    n.flush = wv[`ASC_CTL_FLUSH];
                    n.replay = wv[`ASC_CTL_REPLAY];
                    n.cold = wv[`ASC_CTL_COLD] & ~pd_busy;
                    n.warm = wv[`ASC_CTL_WARM] & ~pd_busy & ~cold_busy;
                end
                `ASC_CAD_OFS: begin
                    wv = wmask({24'h0, s.cmd_rd, s.cmd_idx}, wb_dat_i,
                               wb_sel_i);
                    n.cmd_rd = wv[`ASC_CAD_RD];
                    n.cmd_idx = wv[6:0];
                    n.addr_wr = 1'b1;
                end
                `ASC_CDA_OFS: begin
                    wv = wmask({16'h0, s.cmd_dat}, wb_dat_i, wb_sel_i);
                    n.cmd_dat = wv[15:0];
                    n.data_wr = 1'b1;
                end
                `ASC_STA_OFS: begin
                    wv = wmask('0, wb_dat_i, wb_sel_i);
                    if (wv[`ASC_STA_DONE]) begin
                        n.done = 1'b0;
                    end
                    if (wv[`ASC_STA_RCVD]) begin
                        n.rcvd = 1'b0;
                    end
                end
                `ASC_IEN_OFS: begin
                    wv = wmask({31'h0, s.irq_en}, wb_dat_i, wb_sel_i);
                    n.irq_en = wv[0];
                end
                `ASC_DIV_OFS: begin
                    wv = wmask({24'h0, s.div}, wb_dat_i, wb_sel_i);
                    n.div = wv[7:0];
                end
                default: begin
                    wv = '0;
                end
            endcase
        end
        // Output bit clock for serial framing
        if (s.en && s.fmt == ASC_FMT_SERIAL && s.bckd) begin
            if (s.divcnt == s.div) begin
                n.divcnt = 8'h00;
                n.bclk = ~s.bclk;
            end else begin
                n.divcnt = s.divcnt + 8'h01;
            end
        end else begin
            n.divcnt = 8'h00;
            n.bclk = 1'b0;
        end
        // AC-link framing, bits driven on the rising bit clock edge
        n.bc_q = bc_s;
        rise = bc_s & ~s.bc_q;
        fall = ~bc_s & s.bc_q;
        link = s.en & (s.fmt == ASC_FMT_ACLINK) & ~pd_busy;
        play = s.en & s.replay;
        req_ok = s.addr_wr & (s.cmd_rd | s.data_wr);
        if (!play) begin
            smp = '0;
        end else if (!tx_empty_i) begin
            smp = tx_data_i;
        end else if (s.lsmp) begin
            smp = s.last;
        end else begin
            smp = '0;
        end
        if (!link) begin
            n.pos = 8'h00;
            n.sdo = 1'b0;
            n.osh = '0;
            n.sync = warm_busy;
        end else if (rise) begin
            n.pos = s.pos + 8'h01;
            n.sync = (s.pos < `ASC_SYNC_BITS);
            case (s.pos)
                8'h00: begin
                    n.carry = req_ok;
                    word = {1'b1, req_ok, req_ok & ~s.cmd_rd, play, play,
                            15'h0000};
                end
                `ASC_SLOT1: word = s.carry ? {s.cmd_rd, s.cmd_idx, 12'h000}
                                           : 20'h00000;
                `ASC_SLOT2: word = (s.carry && !s.cmd_rd) ?
                                   {s.cmd_dat, 4'h0} : 20'h00000;
                `ASC_SLOT3, `ASC_SLOT4: begin
                    word = smp;
                    if (play && !tx_empty_i) begin
                        n.pop = 1'b1;
                        n.last = tx_data_i;
                    end
                end
                default: word = s.osh;
            endcase
            n.sdo = word[19];
            n.osh = {word[18:0], 1'b0};
            if (s.pos == `ASC_FRAME_END && s.carry) begin
                n.done = 1'b1;
                n.carry = 1'b0;
                n.addr_wr = 1'b0;
                n.data_wr = 1'b0;
                // Codec power-down write arms the sync holdoff
                n.pd_go = ~s.cmd_rd & (s.cmd_idx == `ASC_PD_IDX) &
                          s.cmd_dat[`ASC_PD_BIT];
            end
        end
        // Incoming bits sampled on the falling edge
        if (link && fall) begin
            n.ish = ish_n;
            if (bi == `ASC_TAG_END) begin
                n.tag = ish_n[15:13];
                n.ready = ish_n[15];
            end
            if (bi == `ASC_S1_END) begin
                n.cidx = ish_n[18:12];
            end
            if (bi == `ASC_S2_END && s.tag[2] && s.tag[1]) begin
                n.st_idx = s.cidx;
                n.st_dat = ish_n[19:4];
                n.rcvd = 1'b1;
            end
        end
        n.rlow = codec_reset_n_o ? 16'h0000 : s.rlow + 16'h0001;
        n.shigh = frame_sync_o ? s.shigh + 16'h0001 : 16'h0000;
        // Soft reset clears every register except the read data and the flush, which it sets, and self-clears
        if (wr && wb_adr_i == `ASC_CFG_OFS && wv[`ASC_CFG_SRST]) begin
            n = '0;
            n.flush = 1'b1;
            n.rdat = s.rdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign irq_o = s.rcvd & s.irq_en;
    assign bit_clk_o = s.bclk;
    assign bit_clk_oe_o = s.en & (s.fmt == ASC_FMT_SERIAL) & s.bckd;
    assign frame_sync_o = s.sync;
    assign frame_sync_oe_o = (s.fmt == ASC_FMT_ACLINK) | s.syncd;
    assign sdata_out_o = s.sdo;
    assign codec_reset_n_o = ~cold_busy;
    assign tx_pop_o = s.pop;
    assign fifo_flush_o = s.flush;
    assign internal_codec_select_o = s.icdc;
    assign justification_select_o = s.amsl;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence sq_cfg_write;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
        wb_adr_i == `ASC_CFG_OFS && wb_sel_i[0];
    endsequence

    sequence sq_sample_slot;
        link && rise && (s.pos == `ASC_SLOT3 || s.pos == `ASC_SLOT4);
    endsequence

    a_reset_disabled: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !s.en && !fifo_flush_o)
        else $error("controller not disabled after reset");
    a_soft_reset: assert property (sq_cfg_write ##0 wb_dat_i[1]
        |=> fifo_flush_o && !s.en ##1 !fifo_flush_o)
        else $error("soft reset did not clear and flush");
    a_flush_keeps: assert property (wb_cyc_i && wb_stb_i && wb_we_i &&
        wb_ack_o && wb_adr_i == `ASC_CTL_OFS && wb_sel_i[0] && wb_dat_i[0]
        |=> fifo_flush_o && $stable(s.en) && $stable(s.div))
        else $error("flush missing or altered registers");
    a_flush_clears: assert property (fifo_flush_o |=> !fifo_flush_o)
        else $error("flush pulse did not self-clear");
    a_cold_width: assert property ($rose(codec_reset_n_o)
        |-> s.rlow >= 16'(COLD_CYC))
        else $error("cold reset pulse too short");
    a_warm_width: assert property ($fell(warm_busy)
        |=> s.shigh >= 16'(WARM_CYC))
        else $error("warm reset sync pulse too short");
    a_pd_quiet: assert property (pd_busy |=> !frame_sync_o)
        else $error("sync raised during power-down holdoff");
    a_done_frame: assert property ($rose(s.done)
        |-> $past(s.pos) == `ASC_FRAME_END && $past(s.carry))
        else $error("command done set outside frame end");
    a_status_cap: assert property ($rose(s.rcvd)
        |-> s.st_idx == $past(s.cidx) && $past(s.tag[1]))
        else $error("status flag set without capture");
    a_irq_raise: assert property ($rose(s.rcvd) && s.irq_en
        |-> irq_o)
        else $error("status interrupt not raised");
    a_replay_zero: assert property (sq_sample_slot ##0 !play
        |=> !sdata_out_o && !tx_pop_o)
        else $error("sample sent with replay off");
    a_empty_zero: assert property (sq_sample_slot ##0 play && tx_empty_i
        && !s.lsmp |=> !sdata_out_o && !tx_pop_o)
        else $error("nonzero sample on empty FIFO");
endmodule

/* File: asc_defines.svh */
// Register offsets, field positions and timing counts of the controller
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

`define ASC_CLK_MHZ 200

`define ASC_CFG_OFS 8'h00
`define ASC_CTL_OFS 8'h04
`define ASC_CAD_OFS 8'h08
`define ASC_CDA_OFS 8'h0c
`define ASC_STA_OFS 8'h10
`define ASC_SAD_OFS 8'h14
`define ASC_SDA_OFS 8'h18
`define ASC_IEN_OFS 8'h1c
`define ASC_DIV_OFS 8'h20

`define ASC_CFG_EN 0
`define ASC_CFG_SRST 1
`define ASC_CFG_ICDC 2
`define ASC_CFG_FMT 3
`define ASC_CFG_BCKD 4
`define ASC_CFG_SYNCD 5
`define ASC_CFG_LSMP 6
`define ASC_CFG_AMSL 7

`define ASC_CTL_FLUSH 0
`define ASC_CTL_REPLAY 1
`define ASC_CTL_COLD 2
`define ASC_CTL_WARM 3

`define ASC_CAD_RD 7
`define ASC_STA_DONE 0
`define ASC_STA_RCVD 1
`define ASC_STA_READY 2
`define ASC_STA_PDHOLD 3

`define ASC_T_COLD_NS 1000
`define ASC_T_WARM_NS 1000
`define ASC_COLD_CYC ((`ASC_T_COLD_NS*`ASC_CLK_MHZ+999)/1000)
`define ASC_WARM_CYC ((`ASC_T_WARM_NS*`ASC_CLK_MHZ+999)/1000)
`define ASC_T_FRAME_NS 20834
`define ASC_PD_FRAMES 4
`define ASC_PD_HOLD_CYC \
    ((`ASC_PD_FRAMES*`ASC_T_FRAME_NS*`ASC_CLK_MHZ+999)/1000)

`define ASC_PD_IDX 7'h26
`define ASC_PD_BIT 12

`define ASC_SYNC_BITS 8'h10
`define ASC_SLOT1 8'h10
`define ASC_SLOT2 8'h24
`define ASC_SLOT3 8'h38
`define ASC_SLOT4 8'h4c
`define ASC_TAG_END 8'h0f
`define ASC_S1_END 8'h23
`define ASC_S2_END 8'h37
`define ASC_FRAME_END 8'hff

`endif

/* File: asc_pkg.sv */
// Types shared by the audio serial controller modules
package asc_pkg;
    typedef enum logic {
        ASC_FMT_ACLINK = 1'b0,
        ASC_FMT_SERIAL = 1'b1
    } asc_fmt_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic en;
        logic icdc;
        asc_fmt_t fmt;
        logic bckd;
        logic syncd;
        logic lsmp;
        logic amsl;
        logic replay;
        logic irq_en;
        logic [7:0] div;
        logic [7:0] divcnt;
        logic bclk;
        logic cmd_rd;
        logic [6:0] cmd_idx;
        logic [15:0] cmd_dat;
        logic addr_wr;
        logic data_wr;
        logic carry;
        logic done;
        logic rcvd;
        logic ready;
        logic [2:0] tag;
        logic [6:0] cidx;
        logic [6:0] st_idx;
        logic [15:0] st_dat;
        logic [7:0] pos;
        logic [19:0] osh;
        logic [19:0] ish;
        logic sync;
        logic sdo;
        logic flush;
        logic cold;
        logic warm;
        logic pd_go;
        logic [19:0] last;
        logic pop;
        logic bc_q;
        logic [15:0] rlow;
        logic [15:0] shigh;
    } asc_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] q;
    } asc_sync_t;

    typedef struct packed {
        logic [15:0] cnt;
    } asc_pulse_t;
endpackage

/* File: asc_pulse.sv */
// Fixed-length busy pulse, retriggered only once idle
`timescale 1ns/1ps
module asc_pulse import asc_pkg::*; #(
    parameter int LEN = 200
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o
);
    asc_pulse_t s;
    asc_pulse_t n;

    always_comb begin
        n = s;
        if (start_i && s.cnt == 16'h0000) begin
            n.cnt = 16'(LEN);
        end else if (s.cnt != 16'h0000) begin
            n.cnt = s.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign busy_o = (s.cnt != 16'h0000);
endmodule

/* File: asc_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module asc_sync3 import asc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] d_i,
    output logic [1:0] q_o
);
    asc_sync_t s;
    asc_sync_t n;

    always_comb begin
        n = s;
        n.s1 = d_i;
        n.s2 = s.s1;
        n.s3 = s.s2;
        for (int i = 0; i < 2; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                n.q[i] = s.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign q_o = s.q;
endmodule

/* File: audio_link_setup_and_codec_access_tb.sv */
// Self-checking bench for the audio serial controller
`timescale 1ns/1ps
`include "asc_defines.svh"
module audio_link_setup_and_codec_access_tb import asc_pkg::*;;
    logic clk_i;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, bit_clk_i, bit_clk_o, bit_clk_oe_o;
    logic frame_sync_o, frame_sync_oe_o, sdata_in_i, sdata_out_o;
    logic codec_reset_n_o, tx_pop_o, fifo_flush_o;
    logic internal_codec_select_o, justification_select_o;
    logic [19:0] tx_data_i = '0;
    logic tx_empty_i = 1'b1;
    logic run = 1'b1;
    logic ret_en = 1'b0;
    logic [6:0] ret_idx = '0;
    logic [15:0] ret_dat = '0;
    logic [19:0] slot3;
    int frames;
    int err_count = 0;
    int checks = 0;
    int flushes = 0;
    int pops = 0;
    int rl = 0;
    int rst_len = 0;
    int hl = 0;
    int sync_len = 0;
    int s;
    logic [31:0] seed = 32'he422269f;
    logic [31:0] q, v, tx;

    asc_ctrl #(.PD_HOLD_CYC(20)) asc_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .bit_clk_i(bit_clk_i),
        .bit_clk_o(bit_clk_o), .bit_clk_oe_o(bit_clk_oe_o),
        .frame_sync_o(frame_sync_o), .frame_sync_oe_o(frame_sync_oe_o),
        .sdata_in_i(sdata_in_i), .sdata_out_o(sdata_out_o),
        .codec_reset_n_o(codec_reset_n_o), .tx_data_i(tx_data_i),
        .tx_empty_i(tx_empty_i), .tx_pop_o(tx_pop_o),
        .fifo_flush_o(fifo_flush_o),
        .internal_codec_select_o(internal_codec_select_o),
        .justification_select_o(justification_select_o));

    asc_codec_model asc_codec_model_inst (
        .run_i(run), .reset_n_i(codec_reset_n_o), .sync_i(frame_sync_o),
        .sdo_i(sdata_out_o), .ret_en_i(ret_en), .ret_idx_i(ret_idx),
        .ret_dat_i(ret_dat), .bclk_o(bit_clk_i), .sdi_o(sdata_in_i),
        .slot3_o(slot3), .frames_o(frames));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task complete_run;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t reg %h want %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t pin %b want %b", $time, got, exp);
        end
    endtask

    task chk_min(input int got, input int lo);
        checks++;
        if (got < lo) begin
            err_count++;
            $display("MISMATCH %0t width %0d below %0d", $time, got, lo);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled high
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        chk_bit(n < 40, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // Poll a status bit; a full frame may pass before it sets
    task poll(input int b);
        int n;
        n = 0;
        do begin
            wb(`ASC_STA_OFS, 1'b0, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 6000);
        chk_bit(q[b], 1'b1);
    endtask

    task wait_frames(input int n);
        int f0, k;
        f0 = frames;
        k = 0;
        while (frames < f0 + n && k < 20000) begin
            @(posedge clk_i);
            k++;
        end
        chk_bit(k < 20000, 1'b1);
    endtask

    always @(posedge clk_i) begin
        if (fifo_flush_o === 1'b1) flushes++;
        if (tx_pop_o === 1'b1) pops++;
        if (codec_reset_n_o === 1'b0) begin
            rl++;
        end else if (rl > 0) begin
            rst_len = rl;
            rl = 0;
        end
        if (frame_sync_o === 1'b1) begin
            hl++;
        end else if (hl > 0) begin
            sync_len = hl;
            hl = 0;
        end
    end

    initial begin
        #450000;
        err_count++;
        complete_run;
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_bit(codec_reset_n_o, 1'b1);
        wb(`ASC_CFG_OFS, 1'b0, 32'h0);
        chk(q, 32'h0);
        wb(8'h24, 1'b0, 32'h0);
        chk(q, 32'h0);
        v = rnd() & 32'hfd;
        if (v[2]) v = (v & 32'h4d) | 32'h8;
        wb(`ASC_CFG_OFS, 1'b1, v);
        wb(`ASC_CFG_OFS, 1'b0, 32'h0);
        chk(q, v);
        chk_bit(internal_codec_select_o, v[2]);
        chk_bit(justification_select_o, v[7]);
        chk_bit(bit_clk_oe_o, v[0] & v[3] & v[4]);
        chk_bit(frame_sync_oe_o, ~v[3] | v[5]);
        tx = rnd() & 32'hff;
        wb(`ASC_DIV_OFS, 1'b1, tx);
        wb(`ASC_DIV_OFS, 1'b0, 32'h0);
        chk(q, tx);
        // Divider settles within one count wrap, then toggles every div+1
        repeat (260) @(posedge clk_i);
        q[0] = bit_clk_o;
        repeat (tx + 1) @(posedge clk_i);
        chk_bit(bit_clk_o, q[0] ^ (v[0] & v[3] & v[4]));
        s = flushes;
        wb(`ASC_CTL_OFS, 1'b1, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(32'(flushes - s), 32'h1);
        wb(`ASC_CFG_OFS, 1'b0, 32'h0);
        chk(q, v);
        wb(`ASC_CTL_OFS, 1'b0, 32'h0);
        chk(q, 32'h0);
        s = flushes;
        wb(`ASC_CFG_OFS, 1'b1, v | 32'h2);
        repeat (3) @(posedge clk_i);
        chk(32'(flushes - s), 32'h1);
        wb(`ASC_CFG_OFS, 1'b0, 32'h0);
        chk(q, 32'h0);
        wb(`ASC_DIV_OFS, 1'b0, 32'h0);
        chk(q, 32'h0);
        wb(`ASC_CFG_OFS, 1'b1, 32'h1);
        wb(`ASC_CTL_OFS, 1'b1, 32'h4);
        repeat (`ASC_COLD_CYC + 10) @(posedge clk_i);
        chk_min(rst_len, `ASC_COLD_CYC);
        wb(`ASC_IEN_OFS, 1'b1, 32'h1);
        wb(`ASC_STA_OFS, 1'b1, 32'h3);
        tx = rnd();
        wb(`ASC_CDA_OFS, 1'b1, tx & 32'hffff);
        wb(`ASC_CAD_OFS, 1'b1, 32'(tx[20:16]));
        poll(`ASC_STA_DONE);
        v = rnd();
        ret_idx <= v[6:0];
        ret_dat <= v[22:7];
        ret_en <= 1'b1;
        poll(`ASC_STA_RCVD);
        ret_en <= 1'b0;
        chk_bit(q[`ASC_STA_READY], 1'b1);
        chk_bit(irq_o, 1'b1);
        wb(`ASC_SAD_OFS, 1'b0, 32'h0);
        chk(q, {25'h0, v[6:0]});
        wb(`ASC_SDA_OFS, 1'b0, 32'h0);
        chk(q, {16'h0, v[22:7]});
        wb(`ASC_STA_OFS, 1'b1, 32'h2);
        wb(`ASC_STA_OFS, 1'b0, 32'h0);
        chk_bit(q[`ASC_STA_RCVD], 1'b0);
        chk_bit(irq_o, 1'b0);
        wb(`ASC_STA_OFS, 1'b1, 32'h1);
        wb(`ASC_CDA_OFS, 1'b1, 32'h1000);
        wb(`ASC_CAD_OFS, 1'b1, 32'h26);
        poll(`ASC_STA_DONE);
        wb(`ASC_STA_OFS, 1'b0, 32'h0);
        chk_bit(q[`ASC_STA_PDHOLD], 1'b1);
        repeat (30) @(posedge clk_i);
        wb(`ASC_STA_OFS, 1'b0, 32'h0);
        chk_bit(q[`ASC_STA_PDHOLD], 1'b0);
        // Head sample stays put, so replay and last sample both show it
        tx = rnd();
        tx_data_i <= tx[19:0];
        for (int i = 0; i < 4; i++) begin
            tx_empty_i <= (i >= 2);
            wb(`ASC_CFG_OFS, 1'b1, (i == 2) ? 32'h41 : 32'h1);
            wb(`ASC_CTL_OFS, 1'b1, (i == 0) ? 32'h0 : 32'h2);
            s = pops;
            wait_frames(2);
            v = (i == 1 || i == 2) ? 32'(tx[19:0]) : 32'h0;
            chk(32'(slot3), v);
            if (i == 1) chk_bit(pops > s, 1'b1);
        end
        wb(`ASC_CFG_OFS, 1'b1, 32'h0);
        run <= 1'b0;
        repeat (20) @(posedge clk_i);
        sync_len = 0;
        wb(`ASC_CTL_OFS, 1'b1, 32'h8);
        repeat (`ASC_WARM_CYC + 20) @(posedge clk_i);
        chk_min(sync_len, `ASC_WARM_CYC);
        complete_run;
    end
endmodule
